// file: hdl/dir_regs.v
// Read-only device identification and die identifier register bank
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "dir_defines.vh"

// Behaviour
// - Identification word read-only at fixed address
// - Bit 31 one: system coprocessor present
// - Bits 30:17 fixed configuration number
// - Bits 16:13 four-bit process code
// - Bit 12 zero: 3.3 V I/O
// - Bit 11 one: peripheral memory parity
// - Bits 10:9 binary 10: program ECC
// - Bit 8 one: RAM ECC present
// - Bits 7:3 five-bit silicon revision
// - Bits 2:0 fixed platform family code
// - Two read-only die registers, 56-bit identifier
// - Die fields: X, Y, wafer, lot, reserved
module dir_regs #(
  parameter [13:0] CFG_NUM  = 14'h0123, // Configuration number, arbitrary value
  parameter [3:0]  PROC     = 4'h6,     // Process code, arbitrary value
  parameter [4:0]  REVISION = 5'h01,    // Silicon revision, arbitrary value
  parameter [2:0]  FAMILY   = 3'h3      // Platform family code, arbitrary value
) (
  // Clock and reset
  input  wire                   mclk,
  input  wire                   rst_b,
  // Register port
  input  wire [`DIR_ADDR_W-1:0] reg_addr,
  input  wire [31:0]            reg_wdata,
  input  wire                   reg_wr,
  input  wire                   reg_rd,
  output reg  [31:0]            reg_rdata_q,
  output reg                    reg_miss_q,
  // Die identifier fuses, stable during reset
  input  wire [31:0]            die_fuse_lo,
  input  wire [23:0]            die_fuse_hi,
  // Decoded identity for other on-chip logic
  output reg  [4:0]             revision_q,
  output reg  [11:0]            die_x_q,
  output reg  [11:0]            die_y_q,
  output reg  [7:0]             wafer_num_q,
  output reg  [23:0]            lot_num_q,
  output reg                    die_lot_number_valid_q
);

  // Address compare used by every decode path
  function hit;
    input [`DIR_ADDR_W-1:0] a;
    input [`DIR_ADDR_W-1:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  // Constant identification word
  wire [31:0] id_word;
  // Held die identifier halves
  wire [31:0] die_lo;
  wire [23:0] die_hi;
  // Die identifier has been frozen
  wire        die_held;
  // Selected read value
  reg  [31:0] rd_mux;
  // Address matches a mapped register
  reg         mapped;
  // Write data deliberately unused; kept for bus completeness
  wire        wdata_unused;

  assign wdata_unused = ^reg_wdata;

  dir_word_pack #(
    .CFG_NUM  (CFG_NUM),
    .PROC     (PROC),
    .REVISION (REVISION),
    .FAMILY   (FAMILY)
  ) u_pack (
    .id_word (id_word)
  );

  dir_fuse_latch u_fuse (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .fuse_lo  (die_fuse_lo),
    .fuse_hi  (die_fuse_hi),
    .die_lo_q (die_lo),
    .die_hi_q (die_hi),
    .held_q   (die_held)
  );

  // Read decode; unmapped addresses give zero
  always @* begin
    rd_mux = `DIR_RST_WORD;
    mapped = 1'b1;
    if (hit(reg_addr, `DIR_OFS_ID_WORD)) begin
      rd_mux = id_word;
    end else if (hit(reg_addr, `DIR_OFS_DIE_WAFER)) begin
      rd_mux = die_lo;
    end else if (hit(reg_addr, `DIR_OFS_DIE_LOT)) begin
      rd_mux = {8'h00, die_hi};
    end else begin
      // Nothing mapped here
      mapped = 1'b0;
    end
  end

  // Read data stands for the one cycle after the strobe only
  always @(posedge mclk) begin
    if (!rst_b) begin
      reg_rdata_q <= `DIR_RST_WORD;
      reg_miss_q  <= 1'b0;
    end else if (reg_rd) begin
      reg_rdata_q <= rd_mux;
      reg_miss_q  <= ~mapped;
    end else begin
      reg_rdata_q <= `DIR_RST_WORD;
      reg_miss_q  <= 1'b0;
    end
  end

  // Decoded identity for other logic, refreshed from the held values and the identification word
  always @(posedge mclk) begin
    if (!rst_b) begin
      revision_q     <= 5'h00;
      die_x_q        <= 12'h000;
      die_y_q        <= 12'h000;
      wafer_num_q    <= 8'h00;
      lot_num_q      <= 24'h000000;
      die_lot_number_valid_q <= 1'b0;
    end else begin
      revision_q     <= id_word[`DIR_REV_MSB:`DIR_REV_LSB];
      die_x_q        <= die_lo[`DIR_X_MSB:`DIR_X_LSB];
      die_y_q        <= die_lo[`DIR_Y_MSB:`DIR_Y_LSB];
      wafer_num_q    <= die_lo[`DIR_WAF_MSB:`DIR_WAF_LSB];
      lot_num_q      <= die_hi[`DIR_LOT_MSB:`DIR_LOT_LSB];
      die_lot_number_valid_q <= die_held;
    end
  end

endmodule

`default_nettype wire

// file: hdl/dir_defines.vh
// Offsets, field positions and fixed values of the identity register bank
`ifndef DIR_DEFINES_VH
`define DIR_DEFINES_VH

// Register byte addresses on the system bus
`define DIR_ADDR_W          28
`define DIR_OFS_DIE_WAFER   28'hfffff7c
`define DIR_OFS_DIE_LOT     28'hfffff80
`define DIR_OFS_ID_WORD     28'hffffff0

// Identification word field positions
`define DIR_COP_BIT         31
`define DIR_CFG_MSB         30
`define DIR_CFG_LSB         17
`define DIR_PROC_MSB        16
`define DIR_PROC_LSB        13
`define DIR_IOV_BIT         12
`define DIR_PAR_BIT         11
`define DIR_FECC_MSB        10
`define DIR_FECC_LSB        9
`define DIR_RECC_BIT        8
`define DIR_REV_MSB         7
`define DIR_REV_LSB         3
`define DIR_FAM_MSB         2
`define DIR_FAM_LSB         0

// Fixed flag values of the identification word
`define DIR_COP_VAL         1'h1
`define DIR_IOV_33V         1'h0
`define DIR_PAR_VAL         1'h1
`define DIR_FECC_VAL        2'h2
`define DIR_RECC_VAL        1'h1

// Die identifier field positions
`define DIR_X_MSB           11
`define DIR_X_LSB           0
`define DIR_Y_MSB           23
`define DIR_Y_LSB           12
`define DIR_WAF_MSB         31
`define DIR_WAF_LSB         24
`define DIR_LOT_MSB         23
`define DIR_LOT_LSB         0
`define DIR_LOT_W           24

// Reset value of every read-data and status flop
`define DIR_RST_WORD        32'h00000000

`endif

// file: hdl/dir_fuse_latch.v
// Capture and hold of the die identifier presented by the fuse array
`timescale 1ns/1ps
`default_nettype none

module dir_fuse_latch (
  // Clock and reset
  input  wire        mclk,
  input  wire        rst_b,
  // Fuse array values, stable during reset
  input  wire [31:0] fuse_lo,
  input  wire [23:0] fuse_hi,
  // Held die identifier
  output reg  [31:0] die_lo_q,
  output reg  [23:0] die_hi_q,
  output reg         held_q
);

  // Follow the fuses while in reset, freeze at release so reads never see a change
  always @(posedge mclk) begin
    if (!rst_b) begin
      die_lo_q <= fuse_lo;
      die_hi_q <= fuse_hi;
      held_q   <= 1'b0;
    end else begin
      // Frozen after release
      held_q   <= 1'b1;
    end
  end

endmodule

`default_nettype wire

// file: hdl/dir_word_pack.v
// Assembly of the constant identification word from its fields
`timescale 1ns/1ps
`default_nettype none
`include "dir_defines.vh"

module dir_word_pack #(
  parameter [13:0] CFG_NUM  = 14'h0123, // Configuration number, arbitrary value
  parameter [3:0]  PROC     = 4'h6,     // Process code, arbitrary value
  parameter [4:0]  REVISION = 5'h01,    // Silicon revision, arbitrary value
  parameter [2:0]  FAMILY   = 3'h3      // Platform family code, arbitrary value
) (
  // Packed identification word
  output wire [31:0] id_word
);

  // Place every field at its bit position
  function [31:0] pack;
    input [13:0] cfg;
    input [3:0]  prc;
    input [4:0]  rev;
    input [2:0]  fam;
    begin
      pack = `DIR_RST_WORD;
      pack[`DIR_COP_BIT] = `DIR_COP_VAL;
      pack[`DIR_CFG_MSB:`DIR_CFG_LSB] = cfg;
      pack[`DIR_PROC_MSB:`DIR_PROC_LSB] = prc;
      pack[`DIR_IOV_BIT] = `DIR_IOV_33V;
      pack[`DIR_PAR_BIT] = `DIR_PAR_VAL;
      pack[`DIR_FECC_MSB:`DIR_FECC_LSB] = `DIR_FECC_VAL;
      pack[`DIR_RECC_BIT] = `DIR_RECC_VAL;
      pack[`DIR_REV_MSB:`DIR_REV_LSB] = rev;
      pack[`DIR_FAM_MSB:`DIR_FAM_LSB] = fam;
    end
  endfunction

  assign id_word = pack(CFG_NUM, PROC, REVISION, FAMILY);

endmodule

`default_nettype wire

// file: test/dir_regs_monitor.sv
// Port checker for the identity register bank
`timescale 1ns/1ps
`default_nettype none
`include "dir_defines.vh"
module dir_regs_monitor #(
  parameter [13:0] CFG_NUM  = 14'h0123,
  parameter [3:0]  PROC     = 4'h6,
  parameter [4:0]  REVISION = 5'h01,
  parameter [2:0]  FAMILY   = 3'h3
) (
  // Clock, reset and register port
  input wire logic                   mclk,
  input wire logic                   rst_b,
  input wire logic [`DIR_ADDR_W-1:0] reg_addr,
  input wire logic [31:0]            reg_wdata,
  input wire logic                   reg_wr,
  input wire logic                   reg_rd,
  input wire logic [31:0]            reg_rdata_q,
  input wire logic                   reg_miss_q,
  // Fuses and decoded identity
  input wire logic [31:0]            die_fuse_lo,
  input wire logic [23:0]            die_fuse_hi,
  input wire logic [4:0]             revision_q,
  input wire logic [11:0]            die_x_q,
  input wire logic [11:0]            die_y_q,
  input wire logic [7:0]             wafer_num_q,
  input wire logic [23:0]            lot_num_q,
  input wire logic                   die_lot_number_valid_q
);
  // Identification word built from its fields
  localparam [31:0] ID_EXP = {1'b1, CFG_NUM, PROC, 5'b01101, REVISION, FAMILY};
  wire logic hit;  // Address decodes to a register
  assign hit = reg_addr == `DIR_OFS_ID_WORD || reg_addr == `DIR_OFS_DIE_WAFER
               || reg_addr == `DIR_OFS_DIE_LOT;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  AST_ID_WORD: assert property (reg_rd && reg_addr == `DIR_OFS_ID_WORD |=> reg_rdata_q == ID_EXP)
    else $error("id word mismatch");
  AST_WAFER: assert property (reg_rd && reg_addr == `DIR_OFS_DIE_WAFER |=>
    reg_rdata_q == {wafer_num_q, die_y_q, die_x_q}) else $error("wafer word mismatch");
  AST_LOT: assert property (reg_rd && reg_addr == `DIR_OFS_DIE_LOT |=>
    reg_rdata_q == {8'h00, lot_num_q}) else $error("lot word mismatch");
  AST_MISS: assert property (reg_rd && !hit |=> reg_miss_q && reg_rdata_q == 0)
    else $error("unmapped read not flagged");
  AST_HIT: assert property (reg_rd && hit |=> !reg_miss_q)
    else $error("mapped read flagged");
  AST_QUIET: assert property (!reg_rd |=> reg_rdata_q == 0 && !reg_miss_q)
    else $error("read data without read");
  AST_FROZEN: assert property (die_lot_number_valid_q |=>
    $stable({lot_num_q, wafer_num_q, die_y_q, die_x_q, revision_q})) else $error("die_lot_number moved");
  AST_VALID_UP: assert property ($rose(rst_b) |-> ##[1:2] die_lot_number_valid_q)
    else $error("die_lot_number valid late");
  AST_REV: assert property (die_lot_number_valid_q |-> revision_q == REVISION)
    else $error("revision mismatch");
  // Main scenarios
  cover property (reg_rd && reg_addr == `DIR_OFS_ID_WORD);
  cover property (reg_miss_q);
  cover property (reg_wr ##1 !reg_wr);
endmodule
bind dir_regs dir_regs_monitor #(.CFG_NUM(CFG_NUM), .PROC(PROC), .REVISION(REVISION),
  .FAMILY(FAMILY)) u_mon (.mclk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata_q, .reg_miss_q, .die_fuse_lo, .die_fuse_hi, .revision_q, .die_x_q,
  .die_y_q, .wafer_num_q, .lot_num_q, .die_lot_number_valid_q);
`default_nettype wire

// file: test/testbench.sv
// Self-checking bench of the identity register bank
`timescale 1ns/1ps
`default_nettype none
`include "dir_defines.vh"
module testbench;
  localparam [13:0] CFG = 14'h2b7c;  // Arbitrary values
  localparam [3:0]  PRC = 4'h9;
  localparam [4:0]  REV = 5'h15;
  localparam [2:0]  FAM = 3'h6;
  localparam [31:0] ID_EXP = {1'b1, CFG, PRC, 5'b01101, REV, FAM};
  logic        mclk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, reg_miss_q, die_lot_number_valid_q;
  logic [27:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0, die_fuse_lo = 0, exp_lo, reg_rdata_q;
  logic [23:0] die_fuse_hi = 0, exp_hi, lot_num_q;
  logic [11:0] die_x_q, die_y_q;
  logic [7:0]  wafer_num_q;
  logic [4:0]  revision_q;
  int          err_total = 0, num_checks = 0;
  always #12.5 mclk = ~mclk;
  dir_regs #(.CFG_NUM(CFG), .PROC(PRC), .REVISION(REV), .FAMILY(FAM)) DUT (.mclk, .rst_b,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q, .reg_miss_q, .die_fuse_lo,
    .die_fuse_hi, .revision_q, .die_x_q, .die_y_q, .wafer_num_q, .lot_num_q, .die_lot_number_valid_q);
  // Compare and count
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task summarize;
    $display("mismatches %0d comparisons %0d", err_total, num_checks);
    if (err_total == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Reset with fuses, then let fuses drift to prove they are frozen
  task do_reset(input logic [31:0] l, input logic [23:0] h);
    @(posedge mclk);
    rst_b <= 0;
    die_fuse_lo <= l;
    die_fuse_hi <= h;
    exp_lo = l;
    exp_hi = h;
    repeat (20) @(posedge mclk);
    rst_b <= 1;
    @(posedge mclk);
    die_fuse_lo <= ~l;
    die_fuse_hi <= ~h;
    repeat (2) @(posedge mclk);
    #1;
  endtask
  task t_fields;
    chk("valid", 32'h1, {31'h0, die_lot_number_valid_q});
    chk("die fields", exp_lo, {wafer_num_q, die_y_q, die_x_q});
    chk("lot", {8'h00, exp_hi}, {8'h00, lot_num_q});
    chk("revision", {27'h0, REV}, {27'h0, revision_q});
  endtask
  // One-cycle read strobe; data stand only in the cycle after it
  task rd(input logic [27:0] a, input logic [31:0] e, input logic m);
    @(posedge mclk);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 0;
    #1;
    chk("rdata", e, reg_rdata_q);
    chk("miss", {31'h0, m}, {31'h0, reg_miss_q});
  endtask
  task t_reads;
    rd(`DIR_OFS_ID_WORD, ID_EXP, 1'b0);
    rd(`DIR_OFS_DIE_WAFER, exp_lo, 1'b0);
    rd(`DIR_OFS_DIE_LOT, {8'h00, exp_hi}, 1'b0);
    rd(28'hffffff4, 32'h0, 1'b1);
    rd(28'hfffff7d, 32'h0, 1'b1);
    repeat (2) @(posedge mclk);
    #1;
    chk("idle rdata", 32'h0, reg_rdata_q);
  endtask
  // Writes of all ones to every register must change nothing
  task t_writes;
    logic [27:0] a [3] = '{`DIR_OFS_ID_WORD, `DIR_OFS_DIE_WAFER, `DIR_OFS_DIE_LOT};
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk);
      reg_wr <= 1;
      reg_addr <= a[i];
      reg_wdata <= 32'hffffffff;
      @(posedge mclk);
      reg_wr <= 0;
      #1;
      chk("write rdata", 32'h0, reg_rdata_q);
    end
    t_reads;
  endtask
  initial begin
    do_reset(32'ha5c37e19, 24'h5a1b2c);
    t_fields;
    t_reads;
    t_writes;
    do_reset(32'h3e08f1d6, 24'h0c4e71);
    t_fields;
    t_reads;
    summarize;
  end
  initial begin
    repeat (1000) @(posedge mclk);
    err_total++;
    summarize;
  end
endmodule
`default_nettype wire
